// ===== verilog/osw_pkg.sv
/*
  Package for the octal switch serial control block: widths, reset values,
  fault timer figures and the structs that carry the pin groups.
  Assumes a 100 MHz system clock; every pin group is asynchronous to it.
*/
package osw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int OSW_NUM_OUT = 8;
  localparam int OSW_FIFO_DEPTH = 16;
  localparam int OSW_CNT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] OSW_ALL_OFF = 8'hFF;
  localparam logic [7:0] OSW_NO_FAULT = 8'h00;
  localparam logic [OSW_CNT_W-1:0] OSW_CNT_RST = 16'h0000;
  localparam int OSW_MSB = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Timing figures
  localparam int OSW_CLK_MHZ = 100;
  localparam int OSW_OPEN_DELAY_US = 50;
  localparam int OSW_SHORT_DELAY_US = 100;
  localparam int OSW_OPEN_DELAY_CYC = OSW_OPEN_DELAY_US * OSW_CLK_MHZ;
  localparam int OSW_SHORT_DELAY_CYC = OSW_SHORT_DELAY_US * OSW_CLK_MHZ;

  ////////////////////////////////////////////////////////////////////////////
  // Link state
  typedef enum logic [0:0]
  {
    OSW_LINK_IDLE = 1'b0,
    OSW_LINK_ACTIVE = 1'b1
  } osw_link_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin groups
  typedef struct packed
  {
    logic sclk;
    logic cs_n;
    logic si;
    logic rst_n;
  } osw_link_in_t;

  typedef struct packed
  {
    logic [7:0] overtemp;
    logic [7:0] drain_threshold;
    logic load_supply_ov;
    logic short_shutdown_select;
  } osw_fault_in_t;

endpackage : osw_pkg

// ===== verilog/osw_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides and a flush input.
  Assumes both sides run on the same clock; reset is synchronous, active high.
*/
module osw_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Status from pointer compare
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;
  assign out_data_o = mem[rd_ptr_reg[AW-1:0]];

  // Storage write
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers
  always_ff @(posedge clk_i)
  begin
    if (rst_i || flush_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

endmodule : osw_fifo

// ===== verilog/osw_serial_ctrl.sv
/*
  Serial control and fault status logic of an eight channel low side switch.
  The serial clock, chip select, data in, reset pin and all fault inputs
  come from outside the clock domain and are sampled by MCLK_I.
  The master is expected to keep the serial clock well below MCLK_I / 4.
*/

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Chip select fall enables data out and loads the eight status bits.
// - Chip select rise queues the shift register in the command buffer for the output latch.
// - Data out changes on each serial clock rise while selected.
// - Data in is sampled on the serial clock fall.
// - Eight bit command, one bit per output; low is on, high is off.
// - Status shifted out shows the outputs from the previous command.
// - Per output temperature, open load and short faults; global over-voltage.
// - Over-temperature shutdown of one output is independent of serial pins.
// - An over-temperature shut output reports off though commanded on.
// - After cooling, an output returns on only after a later on command.
// - Over-voltage holds all outputs off until cleared and rewritten.
// - First transfer after over-voltage returns all ones.
// - One drain comparator per output: open load when off, short when on.
// - Each applied command word starts a fault delay masking open load results.
// - Open load indication clears by itself when the load returns.
// - Status bit high for an off output, low for an on output.
// - Bits shift most significant first; first bit is output seven.
// - Active low reset pin sets the shift register to all ones, all outputs off.
// - With short shutdown on, a shorted output stays off until next write.
module osw_serial_ctrl
#(
  parameter int OPEN_DELAY_CYC = osw_pkg::OSW_OPEN_DELAY_CYC,
  parameter int SHORT_DELAY_CYC = osw_pkg::OSW_SHORT_DELAY_CYC
)
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  // Serial link pins
  input wire osw_pkg::osw_link_in_t LINK_I,
  output logic SO_O,
  output logic SO_OE_O,
  // Fault sense inputs
  input wire osw_pkg::osw_fault_in_t FAULT_I,
  // Command word stream control
  input wire logic LATCH_HOLD_I,
  output logic CMD_READY_O,
  // Power switch gate controls, high turns a switch on
  output logic [7:0] SWITCH_ON_O
);

  import osw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  osw_link_in_t link_meta_reg;
  osw_link_in_t link_sync_reg;
  osw_fault_in_t fault_meta_reg;
  osw_fault_in_t fault_sync_reg;
  logic sclk_prev_reg;
  logic cs_n_prev_reg;
  logic hold_meta_reg;
  logic hold_sync_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic pin_reset;
  osw_link_state_t link_state_reg;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic so_reg;
  logic [7:0] cmd_latch_reg;
  logic [7:0] status_word;
  logic [7:0] drive_on;
  logic [7:0] ot_trip_reg;
  logic [7:0] short_trip_reg;
  logic ov_hold_reg;
  logic [OSW_CNT_W-1:0] delay_cnt_reg;
  logic open_masked;
  logic short_masked;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic apply;

  // True when a command bit asks for the output on
  function automatic logic cmd_is_on(input logic cmd_bit);
    cmd_is_on = (cmd_bit == 1'b0);
  endfunction : cmd_is_on

  // Status bit of one output from its drive and drain level
  function automatic logic status_bit(input logic on, input logic drain_hi,
                                      input logic mask_open);
    if (on)
    begin
      status_bit = drain_hi;
    end
    else
    begin
      status_bit = mask_open ? 1'b1 : drain_hi;
    end
  endfunction : status_bit

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  // Two stage sampling of every pin group
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      link_meta_reg <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0, rst_n: 1'b0};
      link_sync_reg <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0, rst_n: 1'b0};
      hold_meta_reg <= 1'b0;
      hold_sync_reg <= 1'b0;
    end
    else
    begin
      link_meta_reg <= LINK_I;
      link_sync_reg <= link_meta_reg;
      hold_meta_reg <= LATCH_HOLD_I;
      hold_sync_reg <= hold_meta_reg;
    end
  end

  // Fault and comparator inputs, two stages before use
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      fault_meta_reg <= '0;
      fault_sync_reg <= '0;
    end
    else
    begin
      fault_meta_reg <= FAULT_I;
      fault_sync_reg <= fault_meta_reg;
    end
  end

  // Previous levels for edge detection
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      sclk_prev_reg <= 1'b0;
      cs_n_prev_reg <= 1'b1;
    end
    else
    begin
      sclk_prev_reg <= link_sync_reg.sclk;
      cs_n_prev_reg <= link_sync_reg.cs_n;
    end
  end

  // Edge strobes
  assign sclk_rise = link_sync_reg.sclk && !sclk_prev_reg;
  assign sclk_fall = !link_sync_reg.sclk && sclk_prev_reg;
  assign cs_fall = !link_sync_reg.cs_n && cs_n_prev_reg;
  assign cs_rise = link_sync_reg.cs_n && !cs_n_prev_reg;
  assign pin_reset = !link_sync_reg.rst_n;

  ////////////////////////////////////////////////////////////////////////////
  // Link state
  // Selected from chip select fall until its rise
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
      link_state_reg <= OSW_LINK_IDLE;
    else
      case (link_state_reg)
        OSW_LINK_IDLE:
          if (cs_fall)
            link_state_reg <= OSW_LINK_ACTIVE;
        OSW_LINK_ACTIVE:
          if (cs_rise)
            link_state_reg <= OSW_LINK_IDLE;
        default:
          link_state_reg <= OSW_LINK_IDLE;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word
  // Built from the present drive and drain comparators
  always_comb
  begin
    status_word = OSW_ALL_OFF;
    for (int i = 0; i < OSW_NUM_OUT; i++)
    begin
      status_word[i] = status_bit(drive_on[i], fault_sync_reg.drain_threshold[i],
                                  open_masked);
    end
    if (ov_hold_reg)
      status_word = OSW_ALL_OFF;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift register
  // Load status on select, shift data in on clock fall, MSB first
  always_comb
  begin
    shift_next = shift_reg;
    if (cs_fall)
      shift_next = status_word;
    else if (link_state_reg == OSW_LINK_ACTIVE && sclk_fall)
      shift_next = {shift_reg[6:0], link_sync_reg.si};
  end

  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I || pin_reset)
      shift_reg <= OSW_ALL_OFF;
    else
      shift_reg <= shift_next;
  end

  // Data out bit; unaffected by the reset pin
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
      so_reg <= 1'b1;
    else if (cs_fall)
      so_reg <= status_word[OSW_MSB];
    else if (link_state_reg == OSW_LINK_ACTIVE && sclk_rise)
      so_reg <= shift_reg[OSW_MSB];
  end

  assign SO_O = so_reg;
  assign SO_OE_O = (link_state_reg == OSW_LINK_ACTIVE);

  ////////////////////////////////////////////////////////////////////////////
  // Command word buffer
  // Each completed word is queued on chip select rise while the buffer is not full
  osw_fifo
  #(
    .WIDTH(OSW_NUM_OUT),
    .DEPTH(OSW_FIFO_DEPTH)
  )
  u_cmd_fifo
  (
    .clk_i(MCLK_I),
    .rst_i(SYS_RST_I),
    .flush_i(pin_reset),
    .in_valid_i(cs_rise),
    .in_ready_o(CMD_READY_O),
    .in_data_i(shift_reg),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(!hold_sync_reg),
    .out_data_o(fifo_out_data)
  );

  assign apply = fifo_out_valid && !hold_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Output latch
  // Words popped during over-voltage are dropped
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I || pin_reset)
      cmd_latch_reg <= OSW_ALL_OFF;
    else if (fault_sync_reg.load_supply_ov)
      cmd_latch_reg <= OSW_ALL_OFF;
    else if (apply)
      cmd_latch_reg <= fifo_out_data;
  end

  // Over-voltage hold until cleared and a new word is applied
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I || pin_reset)
      ov_hold_reg <= 1'b0;
    else if (fault_sync_reg.load_supply_ov)
      ov_hold_reg <= 1'b1;
    else if (apply)
      ov_hold_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault delay timer
  // Restarted by each applied word, saturates at the longer delay
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
      delay_cnt_reg <= OSW_CNT_RST;
    else if (apply)
      delay_cnt_reg <= OSW_CNT_RST;
    else if (delay_cnt_reg < SHORT_DELAY_CYC[OSW_CNT_W-1:0])
      delay_cnt_reg <= delay_cnt_reg + 1'b1;
  end

  assign open_masked = (delay_cnt_reg < OPEN_DELAY_CYC[OSW_CNT_W-1:0]);
  assign short_masked = (delay_cnt_reg < SHORT_DELAY_CYC[OSW_CNT_W-1:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Per output protection
  // Trip flags: a fault in the apply cycle keeps its flag set
  generate
    for (genvar g = 0; g < OSW_NUM_OUT; g++)
    begin : g_out
      // Over-temperature trip, cleared only by a later write
      always_ff @(posedge MCLK_I)
      begin
        if (SYS_RST_I)
          ot_trip_reg[g] <= 1'b0;
        else if (fault_sync_reg.overtemp[g])
          ot_trip_reg[g] <= 1'b1;
        else if (apply)
          ot_trip_reg[g] <= 1'b0;
      end

      // Short trip when shutdown is selected and the drain stays high
      always_ff @(posedge MCLK_I)
      begin
        if (SYS_RST_I)
          short_trip_reg[g] <= 1'b0;
        else if (fault_sync_reg.short_shutdown_select && drive_on[g] && !short_masked &&
                 fault_sync_reg.drain_threshold[g])
          short_trip_reg[g] <= 1'b1;
        else if (apply)
          short_trip_reg[g] <= 1'b0;
      end

      // Effective drive of this output only
      assign drive_on[g] = cmd_is_on(cmd_latch_reg[g]) && !ot_trip_reg[g] &&
                           !short_trip_reg[g] && !ov_hold_reg;
    end
  endgenerate

  assign SWITCH_ON_O = drive_on;

endmodule : osw_serial_ctrl

// ===== bench/osw_ctrl_props.sv
/*
  Checker for the serial control block, bound to its top.
  Assumes link and fault pins are asynchronous levels seen through MCLK_I.
*/
module osw_ctrl_props
  import osw_pkg::*;
#(
  parameter int OPEN_DELAY_CYC = 40,
  parameter int SHORT_DELAY_CYC = 80
)
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  // Link pins
  input wire osw_pkg::osw_link_in_t LINK_I,
  input wire logic SO_O,
  input wire logic SO_OE_O,
  // Faults and stream
  input wire osw_pkg::osw_fault_in_t FAULT_I,
  input wire logic LATCH_HOLD_I,
  input wire logic CMD_READY_O,
  input wire logic [7:0] SWITCH_ON_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  ////////////////////////
  // Link timing
  chk_oe_select: assert property ($fell(LINK_I.cs_n) |-> ##[2:4] SO_OE_O)
    else $error("data out not enabled after select");
  chk_oe_release: assert property ($rose(LINK_I.cs_n) |-> ##[2:5] !SO_OE_O)
    else $error("data out still enabled after deselect");
  chk_so_on_rise: assert property (SO_OE_O && $past(SO_OE_O) && $changed(SO_O)
    |-> $past(LINK_I.sclk, 2) && !$past(LINK_I.sclk, 6))
    else $error("data out moved without a clock rise");
  chk_no_on_sel: assert property (!LINK_I.cs_n [*6]
    |-> (SWITCH_ON_O & ~$past(SWITCH_ON_O)) == 8'h00)
    else $error("output turned on while selected");

  ////////////////////////
  // Fault and reset pin shutdowns
  chk_ov_off: assert property (FAULT_I.load_supply_ov [*5] |-> SWITCH_ON_O == 8'h00)
    else $error("output on during over-voltage");
  chk_ov_hold: assert property ($fell(FAULT_I.load_supply_ov) ##1 LINK_I.cs_n [*8]
    |-> SWITCH_ON_O == 8'h00)
    else $error("output on before rewrite after over-voltage");
  chk_hot_off: assert property ((FAULT_I.overtemp & $past(FAULT_I.overtemp, 5)
    & SWITCH_ON_O) == 8'h00)
    else $error("hot output still on");
  chk_pin_reset: assert property (!LINK_I.rst_n [*5] |-> SWITCH_ON_O == 8'h00)
    else $error("output on while reset pin low");

  // Main scenarios reached
  cover property ($rose(SO_OE_O));
  cover property (FAULT_I.load_supply_ov ##1 !FAULT_I.load_supply_ov);
  cover property (!CMD_READY_O);
endmodule : osw_ctrl_props

bind osw_serial_ctrl osw_ctrl_props #(.OPEN_DELAY_CYC(OPEN_DELAY_CYC),
  .SHORT_DELAY_CYC(SHORT_DELAY_CYC)) u_props (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
  .LINK_I(LINK_I), .SO_O(SO_O), .SO_OE_O(SO_OE_O), .FAULT_I(FAULT_I),
  .LATCH_HOLD_I(LATCH_HOLD_I), .CMD_READY_O(CMD_READY_O), .SWITCH_ON_O(SWITCH_ON_O));

// ===== bench/osw_spi_master.sv
/*
  Serial master model: eight bit frames, first bit for output seven.
  Assumes its 80 ns link clock is far slower than the block clock.
*/
module osw_spi_master
(
  // Block data out
  input wire logic so_i,
  // Link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: clock low, deselected
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b1;
  end

  // One frame; data in settles mid low phase, data out read at each fall
  task automatic xfer(input logic [7:0] cmd, output logic [7:0] sts);
    cs_n_o = 1'b0;
    #100;
    for (int i = 7; i >= 0; i--)
    begin
      #20 si_o = cmd[i];
      #20 sclk_o = 1'b1;
      #40 sts[i] = so_i;
      sclk_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    si_o = ~cmd[0]; // Released line shows the inverse
    #200;
  endtask : xfer
endmodule : osw_spi_master

// ===== bench/tb_top.sv
/*
  Top bench: master model, load model, random and corner command words.
  Assumes fault delays shortened to 40 and 80 block clock cycles.
*/
module tb_top;
  import osw_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic rst_n = 1'b1;
  logic hold = 1'b0;
  logic ov = 1'b0;
  logic sel = 1'b0;
  logic [7:0] hot = 8'h00;
  logic [7:0] opn = 8'h00;
  logic [7:0] shrt = 8'h00;
  logic [7:0] on, sts, cmd, prev;
  logic [7:0] w [17];
  logic [7:0] cn [4] = '{8'h00, 8'hFF, 8'h7F, 8'hFE};
  logic sclk, cs_n, si, so, oe, rdy;
  int err_total = 0;
  int checks_done = 0;
  osw_link_in_t lk;
  osw_fault_in_t fl;

  // Pins; an off drain sits high unless its load is open
  assign lk = {sclk, cs_n, si, rst_n};
  assign fl = {hot, (~on & ~opn) | shrt, ov, sel};

  // Block clock, 100 MHz
  initial
  begin
    forever #5 mclk = ~mclk;
  end

  osw_serial_ctrl #(.OPEN_DELAY_CYC(40), .SHORT_DELAY_CYC(80)) u_dut (.MCLK_I(mclk),
    .SYS_RST_I(rst), .LINK_I(lk), .SO_O(so), .SO_OE_O(oe), .FAULT_I(fl),
    .LATCH_HOLD_I(hold), .CMD_READY_O(rdy), .SWITCH_ON_O(on));
  osw_spi_master u_mst (.so_i(so), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si));

  ////////////////////////
  // Helpers
  function automatic logic [7:0] exp_sts(input logic [7:0] p, input logic [7:0] o);
    return p & ~o;
  endfunction : exp_sts

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] c, input logic [7:0] e, input int n);
    u_mst.xfer(c, sts);
    chk(sts, e);
    chk({7'h00, oe}, 8'h00);
    tick(n);
  endtask : wr

  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  // Hang guard
  initial
  begin
    #500000;
    err_total++;
    results();
  end

  ////////////////////////
  // Main sequence
  initial
  begin
    void'($urandom(32'hA9D3A2CC));
    tick(12);
    rst = 1'b0;
    tick(6);
    chk(on, 8'h00);
    prev = 8'hFF;
    for (int i = 0; i < 10; i++)
    begin
      cmd = (i < 4) ? cn[i] : 8'($urandom);
      wr(cmd, exp_sts(prev, opn), 60);
      chk(on, ~cmd);
      prev = cmd;
    end
    wr(8'hF0, exp_sts(prev, opn), 60);
    opn = 8'h31;
    tick(4);
    wr(8'hF0, 8'hC0, 0);
    chk(sts ^ 8'hF0, 8'h30);
    wr(8'hF0, 8'hF0, 60);
    opn = 8'h00;
    tick(10);
    wr(8'hF0, 8'hF0, 60);
    hot = 8'h04;
    tick(8);
    chk(on, 8'h0B);
    wr(8'hF0, 8'hF4, 60);
    hot = 8'h00;
    tick(8);
    chk(on, 8'h0B);
    wr(8'hF0, 8'hF4, 60);
    chk(on, 8'h0F);
    ov = 1'b1;
    tick(8);
    chk(on, 8'h00);
    ov = 1'b0;
    tick(8);
    chk(on, 8'h00);
    wr(8'hAA, 8'hFF, 60);
    chk(on, 8'h55);
    sel = 1'b1;
    shrt = 8'h01;
    tick(30);
    chk(on, 8'h54);
    shrt = 8'h00;
    tick(10);
    chk(on, 8'h54);
    wr(8'hAA, 8'hAB, 100);
    chk(on, 8'h55);
    sel = 1'b0;
    hold = 1'b1;
    tick(4);
    for (int i = 0; i < 17; i++)
    begin
      w[i] = 8'($urandom);
      u_mst.xfer(w[i], sts);
    end
    chk({7'h00, rdy}, 8'h00);
    hold = 1'b0;
    tick(40);
    chk({7'h00, rdy}, 8'h01);
    chk(on, ~w[15]);
    rst_n = 1'b0;
    tick(6);
    chk(on, 8'h00);
    rst_n = 1'b1;
    tick(6);
    wr(8'h00, 8'hFF, 60);
    chk(on, 8'hFF);
    results();
  end
endmodule : tb_top
